/* File: design/cpt_pkg.sv */
// ****************************************************************
// constants of the cascaded pulse and warm-up timer
// ****************************************************************
package cpt_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_LOWER_CTRL    = 8'h00;
    localparam logic [7:0] OFF_UPPER_CTRL    = 8'h04;
    localparam logic [7:0] OFF_WIDTH_LOW     = 8'h08;
    localparam logic [7:0] OFF_WIDTH_HIGH    = 8'h0c;
    localparam logic [7:0] OFF_PERIOD_LOW    = 8'h10;
    localparam logic [7:0] OFF_PERIOD_HIGH   = 8'h14;
    localparam logic [7:0] OFF_STATUS        = 8'h18;
    localparam logic [7:0] OFF_COUNT         = 8'h1c;

    // lower control fields
    localparam int LC_SRC_LSB = 4;
    localparam int LC_SRC_MSB = 6;
    localparam int LC_WID_LSB = 0;
    localparam int LC_WID_MSB = 2;
    localparam logic [2:0] LC_WIDTH_16 = 3'h3;

    // upper control fields
    localparam int UC_INIT_BIT = 7;
    localparam int UC_RUN_BIT  = 3;
    localparam int UC_MODE_LSB = 0;
    localparam int UC_MODE_MSB = 2;
    localparam logic [2:0] MODE_PULSE  = 3'h7;
    localparam logic [2:0] MODE_WARMUP = 3'h5;

    // status fields
    localparam int ST_RUN_BIT = 0;
    localparam int ST_FF_BIT  = 1;

    // count source codes
    localparam logic [2:0] SRC_DIV11  = 3'h0;
    localparam logic [2:0] SRC_DIV7   = 3'h1;
    localparam logic [2:0] SRC_DIV5   = 3'h2;
    localparam logic [2:0] SRC_DIV3   = 3'h3;
    localparam logic [2:0] SRC_LOWCLK = 3'h4;
    localparam logic [2:0] SRC_DIV1   = 3'h5;
    localparam logic [2:0] SRC_FULL   = 3'h6;
    localparam logic [2:0] SRC_EXTPIN = 3'h7;

    // prescaler and reset values
    localparam int         PRESCALE_W   = 11;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [7:0] RST_COMPARE  = 8'hff;
    localparam logic [15:0] WARMUP_LOW_MASK = 16'hff00;
endpackage : cpt_pkg

/* File: design/cpt_tick_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// count source selection and count tick between timer modules
// ****************************************************************
interface cpt_tick_if;
    logic [2:0] src_sel;
    logic       tick;
    modport core (output src_sel, input tick);
    modport gen  (input src_sel, output tick);
endinterface : cpt_tick_if

/* File: design/cpt_tick_gen.sv */
`timescale 1ns/1ps
// ****************************************************************
// count tick generator: prescaler and pin edge detection
// ****************************************************************
module cpt_tick_gen (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // source pins
    input  wire logic low_freq_clock,
    input  wire logic ext_count_in,
    // selection and tick
    cpt_tick_if.gen   tk
);
    localparam int PW = cpt_pkg::PRESCALE_W;

    logic [PW-1:0] pre_reg;
    logic [PW-1:0] pre_next;
    logic          lowclk_reg;
    logic          ext_reg;
    logic          tick_reg;
    logic          tick_next;

    // prescaler advance and tick choice
    always_comb begin
        pre_next = pre_reg + PW'(1);
        case (tk.src_sel)
            cpt_pkg::SRC_DIV11:  tick_next = (pre_reg == {PW{1'b1}});
            cpt_pkg::SRC_DIV7:   tick_next = (pre_reg[6:0] == 7'h7f);
            cpt_pkg::SRC_DIV5:   tick_next = (pre_reg[4:0] == 5'h1f);
            cpt_pkg::SRC_DIV3:   tick_next = (pre_reg[2:0] == 3'h7);
            cpt_pkg::SRC_LOWCLK: tick_next = low_freq_clock & ~lowclk_reg;
            cpt_pkg::SRC_DIV1:   tick_next = pre_reg[0];
            cpt_pkg::SRC_FULL:   tick_next = 1'b1;
            cpt_pkg::SRC_EXTPIN: tick_next = ~ext_count_in & ext_reg; // falling edge
            default:             tick_next = 1'b0;
        endcase
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg    <= '0;
            lowclk_reg <= 1'b0;
            ext_reg    <= 1'b0;
            tick_reg   <= 1'b0;
        end else begin
            pre_reg    <= pre_next;
            lowclk_reg <= low_freq_clock;
            ext_reg    <= ext_count_in;
            tick_reg   <= tick_next;
        end
    end

    assign tk.tick = tick_reg;
endmodule : cpt_tick_gen

/* File: design/cpt_timer.sv */
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
// How it works
// R1: two bytes chained as one 16-bit up-counter
// R2: width match inverts flop, counter keeps running
// R3: period match inverts flop, clears, raises irq
// R4: external count levels last two machine cycles
// R5: initial bit sets flop; reset clears flop
// R6: output pin is inverse of flop
// R7: software writes low byte then high byte
// R8: software sets port latch to one
// R9: compare writes act at once, not while running
// R10: stop holds pin; level changes only afterwards
// R11: upper control bit 3 runs or stops
// R12: stopped, clearing bit 7 drives pin high
// R13: 33h, 057h, 05fh program and start pulses
// R14: warm-up mode chains counters into sixteen bits
// R15: warm-up needs initial bits kept at zero
// R16: warm-up compares only upper period byte
// R17: warm-up match clears counter, raises irq
// R18: software handles oscillator switch in handler
// R19: 0100h gives 7.81 ms, ff00h 1.99 s
// R20: 43h and 05h select warm-up on low clock
// R21: warm-up matches never toggle the flop
module cpt_timer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // count source pins
    input  wire logic        low_freq_clock,
    input  wire logic        ext_count_in,
    // timer outputs
    output logic             pulse_gen_output_pin,
    output logic             upper_counter_irq
);
    // the counter picks the source,
    // the generator returns a tick
    // of one cycle per count
    cpt_tick_if tk ();

    // ****************************************************************
    // count tick source
    // ****************************************************************
    cpt_tick_gen u_tick (
        .pclk           (pclk),
        .presetn        (presetn),
        .low_freq_clock (low_freq_clock),
        .ext_count_in   (ext_count_in),
        .tk             (tk.gen)
    );

    // ****************************************************************
    // apb slave
    // ****************************************************************
    // answer state: every bus output
    // is a flop, so no path runs
    // from address to data
    logic        pready_reg;
    logic        pready_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        wr_take;
    logic        addr_ok;

    // control and compare bytes
    logic [7:0]  lower_counter_control_reg;
    logic [7:0]  lower_counter_control_next;
    logic [7:0]  upper_counter_control_reg;
    logic [7:0]  upper_counter_control_next;
    logic [7:0]  width_compare_low_reg;
    logic [7:0]  width_compare_low_next;
    logic [7:0]  width_compare_high_reg;
    logic [7:0]  width_compare_high_next;
    logic [7:0]  period_compare_low_reg;
    logic [7:0]  period_compare_low_next;
    logic [7:0]  period_compare_high_reg;
    logic [7:0]  period_compare_high_next;

    // counter, flop, pin and irq
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        output_flipflop_reg;
    logic        output_flipflop_next;
    logic        pin_reg;
    logic        pin_next;
    logic        irq_reg;
    logic        irq_next;

    // address decode: eight mapped
    // words; any other offset gets
    // pslverr, reads zero and takes
    // no write
    always_comb begin
        case (paddr)
            cpt_pkg::OFF_LOWER_CTRL,
            cpt_pkg::OFF_UPPER_CTRL,
            cpt_pkg::OFF_WIDTH_LOW,
            cpt_pkg::OFF_WIDTH_HIGH,
            cpt_pkg::OFF_PERIOD_LOW,
            cpt_pkg::OFF_PERIOD_HIGH,
            cpt_pkg::OFF_STATUS,
            cpt_pkg::OFF_COUNT:   addr_ok = 1'b1;
            default:              addr_ok = 1'b0;
        endcase
    end

    // a write lands on the edge where pready is seen high;
    // only the low byte lane carries
    // data, so pstrb[0] gates it
    assign wr_take = psel & penable & pready_reg & pwrite & pstrb[0] & addr_ok;

    // one wait state, read data and error prepared with pready;
    // pready rises one cycle after
    // the access phase starts and
    // falls at once, so a held request
    // gets an answer every second cycle;
    // prdata keeps the last answer, zero after a write
    always_comb begin
        pready_next  = psel & penable & ~pready_reg;
        pslverr_next = psel & penable & ~pready_reg & ~addr_ok;
        prdata_next  = prdata_reg;
        if (psel && penable && !pready_reg) begin
            prdata_next = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    cpt_pkg::OFF_LOWER_CTRL:  prdata_next[7:0] = lower_counter_control_reg;
                    cpt_pkg::OFF_UPPER_CTRL:  prdata_next[7:0] = upper_counter_control_reg;
                    cpt_pkg::OFF_WIDTH_LOW:   prdata_next[7:0] = width_compare_low_reg;
                    cpt_pkg::OFF_WIDTH_HIGH:  prdata_next[7:0] = width_compare_high_reg;
                    cpt_pkg::OFF_PERIOD_LOW:  prdata_next[7:0] = period_compare_low_reg;
                    cpt_pkg::OFF_PERIOD_HIGH: prdata_next[7:0] = period_compare_high_reg;
                    cpt_pkg::OFF_STATUS: begin
                        prdata_next[cpt_pkg::ST_RUN_BIT] =
                            upper_counter_control_reg[cpt_pkg::UC_RUN_BIT];
                        prdata_next[cpt_pkg::ST_FF_BIT]  = output_flipflop_reg;
                    end
                    cpt_pkg::OFF_COUNT:       prdata_next[15:0] = count_reg;
                    default:                  prdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // apb answer registers
    // reset leaves the bus idle:
    // no pready, no error, data zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ****************************************************************
    // control and compare registers
    // ****************************************************************
    // run bit, start and mode field
    logic       run_now;
    logic       run_wr;
    logic       ctrl_wr;
    logic [2:0] mode;
    logic       start_evt;

    // a start is a run write while
    // stopped; a run write while
    // running is no start
    assign ctrl_wr   = wr_take & (paddr == cpt_pkg::OFF_UPPER_CTRL);
    assign run_now   = upper_counter_control_reg[cpt_pkg::UC_RUN_BIT];
    assign run_wr    = pwdata[cpt_pkg::UC_RUN_BIT];
    assign mode      = upper_counter_control_reg[cpt_pkg::UC_MODE_MSB:cpt_pkg::UC_MODE_LSB];
    assign start_evt = ctrl_wr & run_wr & ~run_now;

    // plain byte stores; compares are not double-buffered
    // so a compare write acts on the
    // next tick; changing one while
    // running can miss a match for a
    // whole wrap of the counter;
    // status and count are read only
    always_comb begin
        lower_counter_control_next = lower_counter_control_reg;
        upper_counter_control_next = upper_counter_control_reg;
        width_compare_low_next     = width_compare_low_reg;
        width_compare_high_next    = width_compare_high_reg;
        period_compare_low_next    = period_compare_low_reg;
        period_compare_high_next   = period_compare_high_reg;
        // only a committed write stores
        if (wr_take) begin
            case (paddr)
                cpt_pkg::OFF_LOWER_CTRL:  lower_counter_control_next = pwdata[7:0]; // see R13
                cpt_pkg::OFF_UPPER_CTRL:  upper_counter_control_next = pwdata[7:0]; // see R11
                cpt_pkg::OFF_WIDTH_LOW:   width_compare_low_next     = pwdata[7:0]; // see R9
                cpt_pkg::OFF_WIDTH_HIGH:  width_compare_high_next    = pwdata[7:0]; // see R9
                cpt_pkg::OFF_PERIOD_LOW:  period_compare_low_next    = pwdata[7:0]; // see R9
                cpt_pkg::OFF_PERIOD_HIGH: period_compare_high_next   = pwdata[7:0]; // see R9
                default:                  lower_counter_control_next = lower_counter_control_reg;
            endcase
        end
    end

    // control registers
    // compares wake up all ones, so
    // a missing setup gives the
    // longest period, not a zero one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_counter_control_reg <= cpt_pkg::RST_CTRL;
            upper_counter_control_reg <= cpt_pkg::RST_CTRL;
            width_compare_low_reg     <= cpt_pkg::RST_COMPARE;
            width_compare_high_reg    <= cpt_pkg::RST_COMPARE;
            period_compare_low_reg    <= cpt_pkg::RST_COMPARE;
            period_compare_high_reg   <= cpt_pkg::RST_COMPARE;
        end else begin
            lower_counter_control_reg <= lower_counter_control_next;
            upper_counter_control_reg <= upper_counter_control_next;
            width_compare_low_reg     <= width_compare_low_next;
            width_compare_high_reg    <= width_compare_high_next;
            period_compare_low_reg    <= period_compare_low_next;
            period_compare_high_reg   <= period_compare_high_next;
        end
    end

    // source select follows the lower control register;
    // a new source acts at once, so
    // change it only while stopped
    assign tk.src_sel =
        lower_counter_control_reg[cpt_pkg::LC_SRC_MSB:cpt_pkg::LC_SRC_LSB]; // see R20

    // ****************************************************************
    // cascaded counter and output flop
    // ****************************************************************
    // mode decode and the two
    // compare values
    logic        mode_pulse;
    logic        mode_warm;
    logic        wide16;
    logic        active;
    logic [15:0] width_val;
    logic [15:0] period_val;
    logic        width_hit;
    logic        period_hit;

    // the counter moves only with the
    // 16-bit width code and a pulse
    // or warm-up mode; other settings
    // leave it frozen, but a start still clears it
    assign wide16     = (lower_counter_control_reg[cpt_pkg::LC_WID_MSB:cpt_pkg::LC_WID_LSB]
                         == cpt_pkg::LC_WIDTH_16);
    assign mode_pulse = wide16 & (mode == cpt_pkg::MODE_PULSE);
    assign mode_warm  = wide16 & (mode == cpt_pkg::MODE_WARMUP);
    assign active     = run_now & (mode_pulse | mode_warm);
    assign width_val  = {width_compare_high_reg, width_compare_low_reg};
    assign period_val = {period_compare_high_reg, period_compare_low_reg};
    assign width_hit  = (count_reg == width_val);
    // warm-up ignores the low period byte,
    // so its period is a multiple
    // of 256 ticks plus one tick
    assign period_hit = mode_warm
                      ? (count_reg == (period_val & cpt_pkg::WARMUP_LOW_MASK)) // see R16 R19
                      : (count_reg == period_val);

    // counting, matches and flop loading;
    // matches test the count present
    // at a tick; the period match
    // wins, so a width equal to the
    // period toggles once, not twice;
    // a start clears the count so the
    // first period is a full one
    always_comb begin
        count_next           = count_reg;
        output_flipflop_next = output_flipflop_reg;
        // irq is a pulse of one cycle,
        // raised only by a period match
        irq_next             = 1'b0;
        if (start_evt) begin
            count_next = 16'h0000;
        end else if (active && tk.tick) begin
            if (period_hit) begin
                count_next = 16'h0000;                                        // see R3 R17
                irq_next   = 1'b1;                                            // see R3 R17
                // warm-up never toggles, so
                // the pin keeps its initial level
                if (mode_pulse) begin
                    output_flipflop_next = ~output_flipflop_reg;              // see R3 R21
                end
            end else begin
                count_next = count_reg + 16'h0001;                            // see R1 R14
                if (mode_pulse && width_hit) begin
                    output_flipflop_next = ~output_flipflop_reg;              // see R2 R21
                end
            end
        end
        // a control write while stopped loads the initial level,
        // a write that stops the counter leaves the flop alone
        if (ctrl_wr && !run_now) begin
            output_flipflop_next = pwdata[cpt_pkg::UC_INIT_BIT];              // see R5 R12
        end
        // pin follows the final flop value
        pin_next = ~output_flipflop_next;                                     // see R6 R10
    end

    // counter, flop and outputs
    // the pin is registered from the
    // flop's next value, so the two
    // never disagree for a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg           <= 16'h0000;
            output_flipflop_reg <= 1'b0;                                      // see R5
            pin_reg             <= 1'b1;
            irq_reg             <= 1'b0;
        end else begin
            count_reg           <= count_next;
            output_flipflop_reg <= output_flipflop_next;
            pin_reg             <= pin_next;
            irq_reg             <= irq_next;
        end
    end

    // outputs straight from flops,
    // so none glitches on a decode
    assign pready               = pready_reg;
    assign prdata               = prdata_reg;
    assign pslverr              = pslverr_reg;
    assign pulse_gen_output_pin = pin_reg;
    assign upper_counter_irq    = irq_reg;
endmodule : cpt_timer

/* File: tb/cpt_timer_assertions.sv */
`timescale 1ns/1ps
// ****************************************************************
// bus and timer checks on the top ports
// ****************************************************************
module cpt_timer_assertions (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // count sources and outputs
    input  wire logic        low_freq_clock,
    input  wire logic        ext_count_in,
    input  wire logic        pulse_gen_output_pin,
    input  wire logic        upper_counter_irq
);
    logic run_reg;
    logic run_next;
    logic wr_up;
    // committed write to the upper control byte
    assign wr_up = psel & penable & pready & pwrite & pstrb[0]
                 & (paddr == cpt_pkg::OFF_UPPER_CTRL);
    // shadow of the run bit as software last wrote it
    always_comb run_next = wr_up ? pwdata[cpt_pkg::UC_RUN_BIT] : run_reg;
    // register the shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after one wait state");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside a completion");
    rdata_hold_a: assert property ($changed(prdata) |-> pready)
        else $error("prdata changed between transfers");
    irq_pulse_a: assert property (upper_counter_irq |=> !upper_counter_irq)
        else $error("irq longer than one cycle");
    irq_run_a: assert property (upper_counter_irq |->
        $past(run_reg) || $past(run_reg, 2))
        else $error("irq while counter stopped");
    pin_hold_a: assert property ($changed(pulse_gen_output_pin) |->
        $past(run_reg) || $past(wr_up))
        else $error("output pin moved while stopped");
    pin_load_a: assert property (wr_up && !run_reg |=>
        pulse_gen_output_pin == ~$past(pwdata[cpt_pkg::UC_INIT_BIT]))
        else $error("output pin not loaded from initial level");
endmodule : cpt_timer_assertions

bind cpt_timer cpt_timer_assertions cpt_timer_assertions_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .low_freq_clock, .ext_count_in, .pulse_gen_output_pin,
    .upper_counter_irq);

/* File: tb/cpt_count_src.sv */
`timescale 1ns/1ps
// ****************************************************************
// far side count sources: slow oscillator and external pulse pin
// ****************************************************************
module cpt_count_src #(
    parameter int LOW_HALF = 3,
    parameter int EXT_HALF = 4
) (
    // clock
    input  wire logic pclk,
    // bench control
    input  wire logic ext_en,
    // count sources
    output logic      low_freq_clock,
    output logic      ext_count_in
);
    int   lc    = 0;
    int   ec    = 0;
    logic lf_q  = 1'b0;
    logic ext_q = 1'b1;
    // free running slow oscillator
    always @(posedge pclk) begin
        lc <= (lc == LOW_HALF - 1) ? 0 : lc + 1;
        if (lc == LOW_HALF - 1) lf_q <= ~lf_q;
    end
    // external pulses hold each level several cycles, idle high
    always @(posedge pclk) begin
        ec <= (ec == EXT_HALF - 1 || !ext_en) ? 0 : ec + 1;
        if (!ext_en) ext_q <= 1'b1;
        else if (ec == EXT_HALF - 1) ext_q <= ~ext_q;
    end
    // one driver per pin
    assign low_freq_clock = lf_q;
    assign ext_count_in   = ext_q;
endmodule : cpt_count_src

/* File: tb/cpt_timer_tb_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the cascaded timer
// ****************************************************************
module cpt_timer_tb_top;
    localparam int LOW_PER = 6;
    logic        pclk, presetn, psel, penable, pwrite, ext_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic        pready, pslverr, rerr, lfc, ext, pin, irq;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          n;

    // device and far side
    cpt_timer cpt_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .low_freq_clock(lfc),
        .ext_count_in(ext), .pulse_gen_output_pin(pin), .upper_counter_irq(irq));
    cpt_count_src #(.LOW_HALF(LOW_PER / 2), .EXT_HALF(4)) cpt_count_src_inst (
        .pclk, .ext_en, .low_freq_clock(lfc), .ext_count_in(ext));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) mismatches++;
        if (k >= 20) final_report();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'hf);
    endtask : wr

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    task wu(input logic [7:0] d);
        wr(cpt_pkg::OFF_UPPER_CTRL, d);
    endtask : wu

    // compare bytes go low then high
    task setcmp(input logic [15:0] w, input logic [15:0] p);
        wr(cpt_pkg::OFF_WIDTH_LOW, w[7:0]);
        wr(cpt_pkg::OFF_WIDTH_HIGH, w[15:8]);
        wr(cpt_pkg::OFF_PERIOD_LOW, p[7:0]);
        wr(cpt_pkg::OFF_PERIOD_HIGH, p[15:8]);
    endtask : setcmp

    // count edges until pin (p=1) or irq (p=0) is seen at level v
    task waitfor(input bit p, input logic v, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (((p ? pin : irq) !== v) && c < 5000);
        if (c >= 5000) mismatches++;
        if (c >= 5000) final_report();
    endtask : waitfor

    task test_reset;
        chk({31'h0, pin}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(cpt_pkg::OFF_UPPER_CTRL);
        chk(rdat, 32'h0);
        apb(1'b1, cpt_pkg::OFF_WIDTH_LOW, 32'h12, 4'h0);
        rd(cpt_pkg::OFF_WIDTH_LOW);
        chk(rdat, 32'hff);
        rd(8'h20);
        chk({rdat[30:0], rerr}, 32'h1);
    endtask : test_reset

    task test_pulse;
        setcmp(16'h0002, 16'h0004);
        wr(cpt_pkg::OFF_LOWER_CTRL, 8'h33);
        wu(8'h57);
        chk({31'h0, pin}, 32'h1);
        wu(8'h5f);
        waitfor(1'b0, 1'b1, n);
        waitfor(1'b0, 1'b1, n);
        chk(n, 32'd40);
        waitfor(1'b1, 1'b0, n);
        waitfor(1'b1, 1'b1, n);
        chk(n, 32'd16);
    endtask : test_pulse

    task test_stop;
        waitfor(1'b1, 1'b0, n);
        wu(8'h57);
        repeat (60) @(posedge pclk);
        chk({31'h0, pin}, 32'h0);
        rd(cpt_pkg::OFF_STATUS);
        chk(rdat, 32'h2);
        rd(cpt_pkg::OFF_COUNT);
        chk(rdat, 32'h3);
        wu(8'h57);
        chk({31'h0, pin}, 32'h1);
        wu(8'hd7);
        chk({31'h0, pin}, 32'h0);
    endtask : test_stop

    task test_ext;
        setcmp(16'h0001, 16'h0002);
        ext_en <= 1'b1;
        wr(cpt_pkg::OFF_LOWER_CTRL, 8'h73);
        wu(8'h57);
        wu(8'h5f);
        waitfor(1'b0, 1'b1, n);
        waitfor(1'b0, 1'b1, n);
        chk(n, 32'd24);
        wu(8'h57);
        ext_en <= 1'b0;
    endtask : test_ext

    task test_warmup;
        wr(cpt_pkg::OFF_PERIOD_LOW, 8'h05);
        wr(cpt_pkg::OFF_PERIOD_HIGH, 8'h01);
        wr(cpt_pkg::OFF_LOWER_CTRL, 8'h43);
        wu(8'h05);
        wu(8'h0d);
        waitfor(1'b0, 1'b1, n);
        waitfor(1'b0, 1'b1, n);
        chk(n, 257 * LOW_PER);
        chk({31'h0, pin}, 32'h1);
        wu(8'h05);
        rd(cpt_pkg::OFF_STATUS);
        chk(rdat, 32'h0);
    endtask : test_warmup

    // reset, then scenarios in order
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        ext_en = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_pulse();
        test_stop();
        test_ext();
        test_warmup();
        final_report();
    end
endmodule : cpt_timer_tb_top
